/* common/acap_pkg.sv */
// Shared constants, bus carriers and helpers for the audio capture channel.
// Assumes a single 100 MHz clock domain with a synchronous active-low reset.
package acap_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int FIFO_DEPTH = 35;
  localparam int FIFO_W = 36;
  localparam int CNT_W = 6;
  localparam int REM_W = 12;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 6'h23;

  // ****************************************************************
  // Bus commands, instruction fields, timing
  // ****************************************************************
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_JUMP = 4'h7;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 28;
  localparam int LEN_MSB = 11;
  localparam logic [31:0] DWORD_BYTES = 32'h4;
  localparam logic [31:0] FETCH_BYTES = 32'h8;
  localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
  localparam logic [31:0] PC_RST = 32'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic gnt_n;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic [31:0] ad;
    logic par;
  } pci_in_t;

  typedef struct packed {
    logic req_n;
    logic frame_n;
    logic irdy_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
    logic par;
  } pci_out_t;

  // Enables are low while this end drives the line
  typedef struct packed {
    logic frame;
    logic irdy;
    logic cbe;
    logic ad;
    logic par;
  } pci_oe_t;

  typedef struct packed {
    logic busy;
    logic overrun;
    logic perr;
    logic abort;
    logic illegal;
  } status_t;

  localparam pci_out_t OUT_RST = '{1'b1, 1'b1, 1'b1, 4'hF, 32'h0, 1'b0};
  localparam pci_oe_t OE_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  // Even parity bit over address/data and command/byte enables
  function automatic logic even_par(input logic [31:0] ad,
                                    input logic [3:0] cbe);
    even_par = ^{ad, cbe};
  endfunction : even_par

endpackage : acap_pkg

/* src/acap_fifo.sv */
// Sample DWORD buffer for the audio capture channel, flip-flop storage.
// Pushes while full are dropped; assumes the reader pops only when not empty.
`timescale 1ns/10ps
module acap_fifo
  import acap_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic [FIFO_W-1:0] wdata,
  input wire logic pop,
  output logic [FIFO_W-1:0] head,
  output logic [FIFO_W-1:0] head2,
  output logic [CNT_W-1:0] count,
  output logic full
);
  import acap_pkg::*;

  logic [FIFO_W-1:0] mem_r [FIFO_DEPTH];
  logic [FIFO_W-1:0] mem_nxt [FIFO_DEPTH];
  logic [CNT_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt, cnt_r, cnt_nxt;
  logic do_push;

  function automatic logic [CNT_W-1:0] inc_ptr(input logic [CNT_W-1:0] p);
    inc_ptr = (p == FIFO_FULL_CNT - 6'h01) ? 6'h00 : p + 6'h01;
  endfunction : inc_ptr

  assign full = (cnt_r == FIFO_FULL_CNT);
  assign count = cnt_r;
  assign head = mem_r[rd_r];
  assign head2 = mem_r[inc_ptr(rd_r)];
  assign do_push = push && !full;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (do_push) begin
      mem_nxt[wr_r] = wdata;
      wr_nxt = inc_ptr(wr_r);
    end
    if (pop) begin
      rd_nxt = inc_ptr(rd_r);
    end
    cnt_nxt = cnt_r + {5'h00, do_push} - {5'h00, pop};
  end

  // Storage needs no reset; pointers define what is valid
  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_r <= 6'h00;
      rd_r <= 6'h00;
      cnt_r <= 6'h00;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule : acap_fifo

/* src/audio_capture_dma.sv */
// Audio capture DMA channel: packs samples, fetches instructions from host
// memory and bursts sample DWORDs out as an independent bus initiator.
// Assumes bus pins are resolved outside from the enables; one clock domain.
`timescale 1ns/10ps

// What this block does
// [RULE1] Packs 8- or 16-bit samples into DWORDs written to host memory
// [RULE2] Runs independently of the video channel, sharing no state
// [RULE3] Samples are packed continuously, never gated by sync events
// [RULE4] Follows an instruction list in host memory with packed writes
// [RULE5] One 35 by 36 buffer with a 6-bit DWORD counter
// [RULE6] Initiator interface matches the video initiator's
// [RULE7] A retry ends only this channel's burst; it retries later itself
// [RULE8] Read data parity is checked and errors flagged
// [RULE9] All control lives in the bus clock domain, 32-bit wide
// [RULE10] This end never signals target disconnect or retry
// [RULE11] Sustains 1 MB/s digital capture without losing data
// [RULE12] Driven parity makes ones across parity, data and enables even
// [RULE13] Requests the bus for writes only with data waiting; burst ends at empty
module audio_capture_dma
  import acap_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input acap_pkg::pci_in_t PCI_IN,
  output acap_pkg::pci_out_t PCI_OUT,
  output acap_pkg::pci_oe_t PCI_OE_N,
  input wire logic ENABLE,
  input wire logic WIDTH16,
  input wire logic [31:0] START_ADDR,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_DATA,
  output acap_pkg::status_t STATUS
);
  import acap_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_ADDR, S_DATA, S_TURN, S_DECODE
  } state_t;

  // ****************************************************************
  // Sample packer
  // ****************************************************************
  logic [31:0] pack_r, pack_nxt;
  logic [1:0] lane_r, lane_nxt;
  logic push, full;
  logic [FIFO_W-1:0] head, head2;
  logic [CNT_W-1:0] fifo_cnt;
  logic pop;

  always_comb begin
    pack_nxt = pack_r;
    lane_nxt = lane_r;
    push = 1'b0;
    if (SAMPLE_VALID) begin // [RULE3]
      if (WIDTH16) begin // [RULE1]
        pack_nxt[lane_r[0]*16 +: 16] = SAMPLE_DATA;
        push = lane_r[0];
        lane_nxt = lane_r[0] ? 2'h0 : 2'h1;
      end else begin
        pack_nxt[lane_r*8 +: 8] = SAMPLE_DATA[7:0];
        push = (lane_r == 2'h3);
        lane_nxt = lane_r + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pack_r <= 32'h0;
      lane_r <= 2'h0;
    end else begin
      pack_r <= pack_nxt;
      lane_r <= lane_nxt;
    end
  end

  // Upper nibble carries active-high byte lanes for the bus
  acap_fifo u_fifo ( // [RULE5]
    .clk(CLK),
    .nrst(NRST),
    .push(push),
    .wdata({4'hF, pack_nxt}),
    .pop(pop),
    .head(head),
    .head2(head2),
    .count(fifo_cnt),
    .full(full)
  );

  // ****************************************************************
  // Initiator and instruction engine
  // ****************************************************************
  // Own request/grant pair only; video traffic on the bus holds it in S_REQ until idle
  state_t state_r, state_nxt; // [RULE2]
  pci_out_t out_r, out_nxt;
  pci_oe_t oe_r, oe_nxt;
  status_t st_r, st_nxt;
  logic [31:0] pc_r, pc_nxt, addr_r, addr_nxt, w0_r, w0_nxt, w1_r, w1_nxt;
  logic [REM_W-1:0] rem_r, rem_nxt;
  logic is_wr_r, is_wr_nxt, word_r, word_nxt, got_r, got_nxt;
  logic halt_r, halt_nxt, chk_r, chk_nxt;
  logic [31:0] chk_ad_r, chk_ad_nxt;
  logic [3:0] chk_be_r, chk_be_nxt;
  logic [2:0] to_r, to_nxt;
  logic done, ending;

  assign done = !PCI_IN.trdy_n && !out_r.irdy_n;

  always_comb begin
    state_nxt = state_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    st_nxt = st_r;
    pc_nxt = pc_r;
    addr_nxt = addr_r;
    w0_nxt = w0_r;
    w1_nxt = w1_r;
    rem_nxt = rem_r;
    is_wr_nxt = is_wr_r;
    word_nxt = word_r;
    got_nxt = got_r;
    halt_nxt = halt_r;
    to_nxt = to_r;
    chk_nxt = 1'b0;
    chk_ad_nxt = PCI_IN.ad;
    chk_be_nxt = out_r.cbe_n;
    pop = 1'b0;
    ending = 1'b0;
    // Parity follows address/data one clock later, driven only after us
    out_nxt.par = even_par(out_r.ad, out_r.cbe_n); // [RULE12]
    oe_nxt.par = oe_r.ad; // [RULE12]
    unique case (state_r)
      S_IDLE: begin
        if (!ENABLE) begin // [RULE9]
          pc_nxt = START_ADDR;
          rem_nxt = '0;
          halt_nxt = 1'b0;
          st_nxt = '0;
        end else if (!halt_r) begin
          if (rem_r == '0) begin // [RULE4]
            is_wr_nxt = 1'b0;
            word_nxt = 1'b0;
            addr_nxt = pc_r;
            out_nxt.req_n = 1'b0;
            state_nxt = S_REQ;
          end else if (fifo_cnt != '0) begin // [RULE13]
            is_wr_nxt = 1'b1;
            out_nxt.req_n = 1'b0;
            state_nxt = S_REQ;
          end
        end
      end
      S_REQ: begin
        if (!PCI_IN.gnt_n && PCI_IN.frame_n && PCI_IN.irdy_n) begin // [RULE6]
          out_nxt.req_n = 1'b1;
          out_nxt.frame_n = 1'b0;
          out_nxt.ad = addr_r;
          out_nxt.cbe_n = is_wr_r ? CMD_MEM_WR : CMD_MEM_RD;
          oe_nxt.frame = 1'b0;
          oe_nxt.irdy = 1'b0;
          oe_nxt.cbe = 1'b0;
          oe_nxt.ad = 1'b0;
          state_nxt = S_ADDR;
        end
      end
      S_ADDR: begin
        out_nxt.irdy_n = 1'b0;
        to_nxt = 3'h0;
        if (is_wr_r) begin
          out_nxt.ad = head[31:0];
          out_nxt.cbe_n = ~head[35:32];
          out_nxt.frame_n = (rem_r == 12'h001) || (fifo_cnt == 6'h01); // [RULE13]
        end else begin
          out_nxt.cbe_n = BE_ALL_N;
          oe_nxt.ad = 1'b1;
        end
        state_nxt = S_DATA;
      end
      S_DATA: begin
        if (done) begin
          to_nxt = 3'h0;
          addr_nxt = addr_r + DWORD_BYTES;
          if (is_wr_r) begin
            pop = 1'b1; // [RULE1]
            rem_nxt = rem_r - 12'h001;
            out_nxt.ad = head2[31:0];
            out_nxt.cbe_n = ~head2[35:32];
            out_nxt.frame_n = (rem_r == 12'h002) || (fifo_cnt == 6'h02); // [RULE13]
          end else begin
            chk_nxt = 1'b1; // [RULE8]
            if (word_r) begin
              w1_nxt = PCI_IN.ad;
              got_nxt = 1'b1;
            end else begin
              w0_nxt = PCI_IN.ad;
              out_nxt.frame_n = 1'b1;
            end
            word_nxt = 1'b1;
          end
          ending = out_r.frame_n || !PCI_IN.stop_n;
        end else if (!PCI_IN.stop_n) begin
          ending = 1'b1; // [RULE7]
        end else if (PCI_IN.devsel_n) begin
          to_nxt = to_r + 3'h1;
          if (to_r == DEVSEL_LIMIT) begin
            st_nxt.abort = 1'b1;
            halt_nxt = 1'b1;
            ending = 1'b1;
          end
        end
        if (ending) begin
          // Retried or cut fetches restart whole from the program counter
          out_nxt.frame_n = 1'b1;
          out_nxt.irdy_n = 1'b1;
          oe_nxt.ad = 1'b1;
          state_nxt = S_TURN;
        end
      end
      S_TURN: begin
        oe_nxt.frame = 1'b1;
        oe_nxt.irdy = 1'b1;
        oe_nxt.cbe = 1'b1;
        got_nxt = 1'b0;
        state_nxt = got_r ? S_DECODE : S_IDLE;
      end
      S_DECODE: begin
        state_nxt = S_IDLE;
        pc_nxt = pc_r + FETCH_BYTES;
        if (w0_r[OP_MSB:OP_LSB] == OP_WRITE) begin // [RULE4]
          addr_nxt = w1_r;
          rem_nxt = w0_r[LEN_MSB:0];
        end else if (w0_r[OP_MSB:OP_LSB] == OP_JUMP) begin
          pc_nxt = w1_r;
        end else begin
          st_nxt.illegal = 1'b1;
          halt_nxt = 1'b1;
        end
      end
    endcase
    // Flags set after the case so a fresh event outlasts an idle clear
    if (push && full) begin
      st_nxt.overrun = 1'b1; // [RULE11]
    end
    if (chk_r && even_par(chk_ad_r, chk_be_r) != PCI_IN.par) begin
      st_nxt.perr = 1'b1; // [RULE8]
    end
    st_nxt.busy = (state_nxt != S_IDLE);
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_r <= S_IDLE;
      out_r <= OUT_RST;
      oe_r <= OE_RST;
      st_r <= '0;
      pc_r <= PC_RST;
      addr_r <= PC_RST;
      w0_r <= 32'h0;
      w1_r <= 32'h0;
      rem_r <= '0;
      is_wr_r <= 1'b0;
      word_r <= 1'b0;
      got_r <= 1'b0;
      halt_r <= 1'b0;
      to_r <= 3'h0;
      chk_r <= 1'b0;
      chk_ad_r <= 32'h0;
      chk_be_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      addr_r <= addr_nxt;
      w0_r <= w0_nxt;
      w1_r <= w1_nxt;
      rem_r <= rem_nxt;
      is_wr_r <= is_wr_nxt;
      word_r <= word_nxt;
      got_r <= got_nxt;
      halt_r <= halt_nxt;
      to_r <= to_nxt;
      chk_r <= chk_nxt;
      chk_ad_r <= chk_ad_nxt;
      chk_be_r <= chk_be_nxt;
    end
  end

  // Only initiator pins exist here: no target termination can be driven
  assign PCI_OUT = out_r; // [RULE10]
  assign PCI_OE_N = oe_r;
  assign STATUS = st_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_req_needs_data: assert property ( // [RULE13]
    @(posedge CLK) disable iff (!NRST)
    (state_r == S_REQ && is_wr_r) |-> fifo_cnt != '0)
    else $error("write request raised with empty buffer");

  a_burst_ends_empty: assert property ( // [RULE13]
    @(posedge CLK) disable iff (!NRST)
    (state_r == S_ADDR && is_wr_r && fifo_cnt == 6'h01) |=> out_r.frame_n)
    else $error("burst not ended on last buffered word");

  a_parity_even: assert property ( // [RULE12]
    @(posedge CLK) disable iff (!NRST)
    !oe_r.ad |=> out_r.par == ^{$past(out_r.ad), $past(out_r.cbe_n)})
    else $error("driven parity not even");

  a_buffer_bound: assert property ( // [RULE5]
    @(posedge CLK) disable iff (!NRST)
    fifo_cnt <= FIFO_FULL_CNT)
    else $error("buffer count beyond depth");

  a_pop_in_data: assert property ( // [RULE1]
    @(posedge CLK) disable iff (!NRST)
    pop |-> (state_r == S_DATA && is_wr_r && done))
    else $error("buffer popped outside a write data phase");

  a_retry_release: assert property ( // [RULE7]
    @(posedge CLK) disable iff (!NRST)
    (state_r == S_DATA && !PCI_IN.stop_n)
      |=> state_r == S_TURN ##1 (state_r == S_IDLE || state_r == S_DECODE))
    else $error("retry did not release the bus");

  a_overrun_flag: assert property ( // [RULE11]
    @(posedge CLK) disable iff (!NRST)
    (push && full) |=> STATUS.overrun)
    else $error("lost DWORD not flagged");

  a_fetch_decode: assert property ( // [RULE4]
    @(posedge CLK) disable iff (!NRST)
    (state_r == S_TURN && got_r) |=> state_r == S_DECODE ##1 state_r == S_IDLE)
    else $error("fetched instruction not decoded");

  a_perr_flag: assert property ( // [RULE8]
    @(posedge CLK) disable iff (!NRST)
    (chk_r && even_par(chk_ad_r, chk_be_r) != PCI_IN.par)
      |=> STATUS.perr)
    else $error("read parity error not flagged");

endmodule : audio_capture_dma

/* bench/acap_host_model.sv */
// Host bridge and memory model that answers the audio channel's bursts.
// Assumes bus levels arrive resolved; drives target-side lines and the grant only.
`timescale 1ns/10ps
module acap_host_model
  import acap_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input acap_pkg::pci_in_t bus,
  input wire logic req_n,
  input wire logic [3:0] cbe_n,
  input wire logic [1:0] waits,
  input wire logic no_gnt,
  input wire logic no_devsel,
  input wire logic retry_req,
  input wire logic bad_par,
  output logic gnt_n,
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n,
  output logic [31:0] ad_out,
  output logic ad_oe_n,
  output logic par_out,
  output logic par_oe_n
);
  // ****
  // Target side
  // ****
  logic [31:0] mem [0:255];
  logic [7:0] addr;
  logic [1:0] wcnt;
  logic in_tx, wr, armed, hit;
  assign ad_out = mem[addr];
  assign ad_oe_n = !(in_tx && !wr && !devsel_n);
  assign hit = armed && cbe_n == CMD_MEM_WR;
  always @(posedge clk) begin
    par_out <= ^{ad_out, cbe_n} ^ bad_par;
    par_oe_n <= ad_oe_n;
    if (retry_req) armed <= 1'b1;
    if (!nrst) begin
      {gnt_n, devsel_n, trdy_n, stop_n, par_oe_n} <= 5'h1F;
      {in_tx, armed} <= 2'h0;
    end else begin
      gnt_n <= req_n | no_gnt;
      if (!in_tx) begin
        if (!bus.frame_n && !no_devsel) begin
          in_tx <= 1'b1;
          addr <= bus.ad[9:2];
          wr <= cbe_n == CMD_MEM_WR;
          devsel_n <= 1'b0;
          stop_n <= !hit;
          armed <= armed && !hit;
          trdy_n <= hit || waits != 2'h0;
          wcnt <= waits;
        end
      end else begin
        if (!bus.irdy_n && !trdy_n) begin
          if (wr) mem[addr] <= bus.ad;
          addr <= addr + 8'h1;
          trdy_n <= waits != 2'h0;
          wcnt <= waits;
        end else if (stop_n && trdy_n) begin
          trdy_n <= wcnt > 2'h1;
          wcnt <= wcnt - 2'h1;
        end
        // Slow answers still end cleanly once the master lets go
        if (bus.frame_n && (bus.irdy_n || !trdy_n))
          {in_tx, devsel_n, trdy_n, stop_n} <= 4'h7;
      end
    end
  end
endmodule : acap_host_model

/* bench/tb_audio_capture_dma_channel.sv */
// Self-checking bench for the audio capture DMA channel.
// Assumes one 100 MHz clock and the host model on the far side.
`timescale 1ns/10ps
module tb_audio_capture_dma_channel;
  import acap_pkg::*;
  // ****
  // Wiring
  // ****
  logic CLK, NRST, ENABLE, WIDTH16, SAMPLE_VALID;
  logic [31:0] START_ADDR;
  logic [15:0] SAMPLE_DATA;
  pci_in_t bus;
  pci_out_t PCI_OUT;
  pci_oe_t PCI_OE_N;
  status_t STATUS;
  logic gnt_n, devsel_n, trdy_n, stop_n, m_ad_oe_n, m_par, m_par_oe_n;
  logic no_gnt, no_devsel, retry_req, bad_par, par_w;
  logic [1:0] waits;
  logic [31:0] m_ad, ad_w;
  logic [3:0] cbe_w;
  logic [31:0] last_ad = 32'h0;
  logic [3:0] last_cbe = 4'h0;
  logic last_par = 1'b0;
  logic [31:0] seed = 32'h7EE7;
  logic [31:0] smp [0:71];
  int n_mismatch = 0;
  int checked = 0;

  // Released AD, PAR and C/BE lines show the inverse of their last level
  assign ad_w = !PCI_OE_N.ad ? PCI_OUT.ad : !m_ad_oe_n ? m_ad : ~last_ad;
  assign par_w = !PCI_OE_N.par ? PCI_OUT.par :
                 !m_par_oe_n ? m_par : ~last_par;
  assign cbe_w = !PCI_OE_N.cbe ? PCI_OUT.cbe_n : ~last_cbe;
  assign bus = '{gnt_n, PCI_OE_N.frame | PCI_OUT.frame_n,
                 PCI_OE_N.irdy | PCI_OUT.irdy_n, trdy_n, stop_n,
                 devsel_n, ad_w, par_w};

  audio_capture_dma u_dut (.CLK(CLK), .NRST(NRST), .PCI_IN(bus),
    .PCI_OUT(PCI_OUT), .PCI_OE_N(PCI_OE_N), .ENABLE(ENABLE),
    .WIDTH16(WIDTH16), .START_ADDR(START_ADDR),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA),
    .STATUS(STATUS));
  acap_host_model u_host (.clk(CLK), .nrst(NRST), .bus(bus),
    .req_n(PCI_OUT.req_n), .cbe_n(cbe_w), .waits(waits),
    .no_gnt(no_gnt), .no_devsel(no_devsel), .retry_req(retry_req),
    .bad_par(bad_par), .gnt_n(gnt_n), .devsel_n(devsel_n),
    .trdy_n(trdy_n), .stop_n(stop_n), .ad_out(m_ad),
    .ad_oe_n(m_ad_oe_n), .par_out(m_par), .par_oe_n(m_par_oe_n));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] exp_word(input int i, input logic w16);
    if (w16) return {smp[2*i+1][15:0], smp[2*i][15:0]};
    return {smp[4*i+3][7:0], smp[4*i+2][7:0], smp[4*i+1][7:0],
            smp[4*i][7:0]};
  endfunction : exp_word

  function automatic int dst(input int i);
    return i < 8 ? 32'h80 + i : 32'hB8 + i;
  endfunction : dst

  // Parity the channel drives lags its address/data by one cycle
  always @(posedge CLK) begin
    if (NRST && !PCI_OE_N.par) chk(PCI_OUT.par, ^{last_ad, last_cbe});
    last_ad <= ad_w;
    last_cbe <= cbe_w;
    last_par <= par_w;
  end

  task automatic wait_st(input logic [4:0] m);
    for (int i = 0; i < 3000 && (STATUS & m) !== m; i++) @(posedge CLK);
  endtask : wait_st

  task automatic clr(input logic [31:0] a);
    for (int i = 0; i < 100 && STATUS.busy !== 1'b0; i++) @(posedge CLK);
    ENABLE <= 1'b0;
    START_ADDR <= a;
    repeat (4) @(posedge CLK);
    chk(STATUS, 5'h00);
  endtask : clr

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      SAMPLE_VALID <= 1'b1;
      SAMPLE_DATA <= smp[i][15:0];
    end
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
  endtask : send

  // Two write instructions split by a jump, then an undefined opcode
  task automatic run(input logic w16, input logic [1:0] w, input logic rt);
    for (int i = 0; i < 72; i++) smp[i] = rnd();
    smp[0] = 32'hFFFF;
    smp[1] = 32'h0;
    clr(32'h0);
    for (int i = 0; i < 12; i++) u_host.mem[dst(i)] = ~exp_word(i, w16);
    WIDTH16 <= w16;
    waits <= w;
    retry_req <= rt;
    @(posedge CLK);
    retry_req <= 1'b0;
    ENABLE <= 1'b1;
    send(w16 ? 24 : 48);
    wait_st(5'h01);
    chk(STATUS & 5'h0F, 5'h01);
    for (int i = 0; i < 12; i++) chk(u_host.mem[dst(i)], exp_word(i, w16));
  endtask : run

  initial begin
    {NRST, ENABLE, WIDTH16, SAMPLE_VALID} = 4'h0;
    {no_gnt, no_devsel, retry_req, bad_par} = 4'h0;
    START_ADDR = 32'h0;
    SAMPLE_DATA = 16'h0;
    waits = 2'h0;
    u_host.mem[0] = {OP_WRITE, 16'h0, 12'h8};
    u_host.mem[1] = 32'h200;
    u_host.mem[2] = {OP_JUMP, 28'h0};
    u_host.mem[3] = 32'h40;
    u_host.mem[16] = {OP_WRITE, 16'h0, 12'h4};
    u_host.mem[17] = 32'h300;
    u_host.mem[18] = 32'h0;
    u_host.mem[19] = 32'h0;
    repeat (3) @(posedge CLK);
    chk(PCI_OUT, OUT_RST);
    chk(PCI_OE_N, OE_RST);
    NRST <= 1'b1;
    run(1'b0, 2'h0, 1'b0);
    run(1'b1, 2'h2, 1'b1);
    run(1'b0, 2'h1, 1'b1);
    clr(32'h48);
    bad_par <= 1'b1;
    ENABLE <= 1'b1;
    wait_st(5'h05);
    chk(STATUS.perr, 1'b1);
    clr(32'h48);
    bad_par <= 1'b0;
    no_devsel <= 1'b1;
    ENABLE <= 1'b1;
    wait_st(5'h02);
    chk(STATUS & 5'h0F, 5'h02);
    clr(32'h0);
    no_devsel <= 1'b0;
    no_gnt <= 1'b1;
    WIDTH16 <= 1'b1;
    ENABLE <= 1'b1;
    send(72);
    repeat (3) @(posedge CLK);
    chk(STATUS.overrun, 1'b1);
    chk(PCI_OE_N.frame, 1'b1);
    stop_test();
  end

  // Whole run is well under this span
  initial begin
    #500us;
    n_mismatch++;
    stop_test();
  end
endmodule : tb_audio_capture_dma_channel
